// >>> verilog/spc_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// shared sizes, codes and helpers of the pipeline control
package spc_pkg;
	// queue sizes and per-cycle limits
	localparam int IQ_DEPTH = 6;
	localparam int CQ_DEPTH = 6;
	localparam int NUM_UNITS = 6;
	localparam int DISP_SCAN = 3;
	localparam int DISP_NB_SLOTS = 2;
	localparam int DISP_NB_MAX = 2;
	localparam int RET_MAX = 2;
	localparam int NUM_AREGS = 16;
	// field widths
	localparam int TAG_W = 3;
	localparam int AREG_W = 4;
	localparam int VEC_W = 16;
	localparam int CNT_W = 3;
	// execution stage depths
	localparam int FPU_STAGES = 3;
	localparam int LSU_STAGES = 2;
	localparam int BASE_STAGES = 1;
	// unit indices
	localparam int U_INT0 = 0;
	localparam int U_INT1 = 1;
	localparam int U_FPU = 2;
	localparam int U_LSU = 3;
	localparam int U_SRU = 4;
	localparam int U_BR = 5;
	// reset values
	localparam logic [CNT_W-1:0] CNT_RST = 3'h0;
	localparam logic [TAG_W-1:0] HEAD_RST = 3'h0;
	// operand source select
	localparam logic [1:0] SRC_ARCH = 2'h0;
	localparam logic [1:0] SRC_RENAME = 2'h1;
	localparam logic [1:0] SRC_TAG = 2'h2;

	typedef enum logic [2:0] {
		C_INT = 3'h0,
		C_FPU = 3'h1,
		C_LSU = 3'h2,
		C_SRU = 3'h3,
		C_BR = 3'h4
	} spc_class_t;

	// instruction queue entry; register numbers carry the fp file in the top bit
	typedef struct packed {
		spc_class_t cls;
		logic has_src;
		logic [AREG_W-1:0] src;
		logic has_dest;
		logic [AREG_W-1:0] dest;
		logic ctr;
		logic lr;
	} spc_iqe_t;

	// completion queue payload
	typedef struct packed {
		logic has_dest;
		logic [AREG_W-1:0] dest;
		logic ctr;
		logic lr;
	} spc_cqe_t;

	function automatic int unit_stages(input int u);
		return (u == U_FPU) ? FPU_STAGES : ((u == U_LSU) ? LSU_STAGES : BASE_STAGES);
	endfunction

	// modulo add over the completion queue ring
	function automatic logic [TAG_W-1:0] tag_add(input logic [TAG_W-1:0] a, input int b);
		int s;
		s = int'(a) + b;
		if (s >= CQ_DEPTH) s = s - CQ_DEPTH;
		return TAG_W'(s);
	endfunction
endpackage

// >>> verilog/spc_xpipe.sv
////////////////////////////////////////////////////////////////////////////////
// staging of one execution unit: DEPTH stages, whole pipe stalls on hold
module spc_xpipe
	import spc_pkg::*;
#(
	parameter int DEPTH = 1
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_flush,
	input wire logic i_issue,
	input wire logic [TAG_W-1:0] i_tag,
	input wire logic i_hold,
	output logic o_ready,
	output logic o_fin,
	output logic [TAG_W-1:0] o_fin_tag
);
	logic [DEPTH-1:0] v_r, v_nxt;
	logic [DEPTH-1:0][TAG_W-1:0] t_r, t_nxt;

	// stage zero frees when empty or when the pipe moves
	assign o_ready = !v_r[0] || !i_hold;
	assign o_fin = v_r[DEPTH-1] && !i_hold;
	assign o_fin_tag = t_r[DEPTH-1];

	// shift one stage per cycle unless held, latch the issued instruction
	always_comb begin
		v_nxt = v_r;
		t_nxt = t_r;
		if (!i_hold) begin
			v_nxt[0] = 1'b0;
			for (int i = 1; i < DEPTH; i++) begin
				v_nxt[i] = v_r[i-1];
				t_nxt[i] = t_r[i-1];
			end
		end
		if (i_issue) begin
			v_nxt[0] = 1'b1;
			t_nxt[0] = i_tag;
		end
		if (i_flush) v_nxt = '0;
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			v_r <= '0;
			t_r <= '0;
		end else begin
			v_r <= v_nxt;
			t_r <= t_nxt;
		end
	end
endmodule

// >>> verilog/spc_cq.sv
////////////////////////////////////////////////////////////////////////////////
// six-entry completion queue; entry index doubles as rename register number
module spc_cq
	import spc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic [1:0] i_alloc_n,
	input wire spc_cqe_t i_alloc_ent [DISP_SCAN],
	input wire logic [NUM_UNITS-1:0] i_fin,
	input wire logic [NUM_UNITS-1:0] i_exc,
	input wire logic [NUM_UNITS-1:0][TAG_W-1:0] i_fin_tag,
	input wire logic [NUM_UNITS-1:0][VEC_W-1:0] i_vec,
	output logic [TAG_W-1:0] o_tail,
	output logic [CNT_W-1:0] o_free,
	output logic [CQ_DEPTH-1:0] o_done,
	output logic [RET_MAX-1:0] o_ret,
	output logic [RET_MAX-1:0][TAG_W-1:0] o_ret_tag,
	output spc_cqe_t o_ret_ent [RET_MAX],
	output logic o_exc_take,
	output logic [VEC_W-1:0] o_exc_vec
);
	logic [TAG_W-1:0] head_r, head_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	spc_cqe_t ent_r [CQ_DEPTH];
	spc_cqe_t ent_nxt [CQ_DEPTH];
	logic [CQ_DEPTH-1:0] done_r, done_nxt, exc_r, exc_nxt;
	logic [CQ_DEPTH-1:0][VEC_W-1:0] vec_r, vec_nxt;

	assign o_tail = tag_add(head_r, int'(cnt_r));
	assign o_free = CNT_W'(CQ_DEPTH - int'(cnt_r));
	assign o_done = done_r;
	assign o_exc_take = (cnt_r != CNT_RST) && done_r[head_r] && exc_r[head_r];
	assign o_exc_vec = vec_r[head_r];

	// in-order retire from the two oldest entries, allocation, finish marks
	always_comb begin
		logic ok;
		logic [TAG_W-1:0] tg;
		int nret;
		ok = 1'b1;
		tg = '0;
		nret = 0;
		o_ret = '0;
		for (int k = 0; k < RET_MAX; k++) begin
			tg = tag_add(head_r, k);
			o_ret_tag[k] = tg;
			o_ret_ent[k] = ent_r[tg];
			// a younger entry never passes an older one
			if (ok && k < int'(cnt_r) && done_r[tg] && !exc_r[tg]) begin
				o_ret[k] = 1'b1;
				nret = nret + 1;
			end else begin
				ok = 1'b0;
			end
		end
		head_nxt = tag_add(head_r, nret);
		cnt_nxt = CNT_W'(int'(cnt_r) - nret + int'(i_alloc_n));
		ent_nxt = ent_r;
		done_nxt = done_r;
		exc_nxt = exc_r;
		vec_nxt = vec_r;
		// each dispatched instruction takes the next free entry
		for (int k = 0; k < DISP_SCAN; k++) begin
			tg = tag_add(head_r, int'(cnt_r) + k);
			if (k < int'(i_alloc_n)) begin
				ent_nxt[tg] = i_alloc_ent[k];
				done_nxt[tg] = 1'b0;
				exc_nxt[tg] = 1'b0;
			end
		end
		// finish and exception reports from the units
		for (int u = 0; u < NUM_UNITS; u++) begin
			if (i_fin[u]) begin
				done_nxt[i_fin_tag[u]] = 1'b1;
				exc_nxt[i_fin_tag[u]] = i_exc[u];
				vec_nxt[i_fin_tag[u]] = i_vec[u];
			end
		end
		// the excepting head cancels itself and every younger entry
		if (o_exc_take) begin
			head_nxt = head_r;
			cnt_nxt = CNT_RST;
			done_nxt = '0;
			exc_nxt = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			head_r <= HEAD_RST;
			cnt_r <= CNT_RST;
			done_r <= '0;
			exc_r <= '0;
			vec_r <= '0;
			for (int k = 0; k < CQ_DEPTH; k++) ent_r[k] <= '0;
		end else begin
			head_r <= head_nxt;
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
			exc_r <= exc_nxt;
			vec_r <= vec_nxt;
			ent_r <= ent_nxt;
		end
	end
endmodule

// >>> verilog/spc_pipe_ctrl.sv
////////////////////////////////////////////////////////////////////////////////
// four-stage superscalar pipeline control: fetch fold, dispatch, execute, complete

module spc_pipe_ctrl
	import spc_pkg::*;
(
	input wire logic I_CLOCK,
	input wire logic I_SRST,
	input wire logic I_FETCH_VALID,
	input wire logic [2:0] I_FETCH_CLASS,
	input wire logic I_FETCH_HAS_SRC,
	input wire logic [AREG_W-1:0] I_FETCH_SRC,
	input wire logic I_FETCH_HAS_DEST,
	input wire logic [AREG_W-1:0] I_FETCH_DEST,
	input wire logic I_FETCH_UPD_CTR,
	input wire logic I_FETCH_UPD_LR,
	input wire logic [NUM_UNITS-1:0] I_UNIT_HOLD,
	input wire logic [NUM_UNITS-1:0] I_UNIT_EXC,
	input wire logic [NUM_UNITS-1:0][VEC_W-1:0] I_UNIT_VEC,
	output logic O_FETCH_READY,
	output logic O_BR_FOLD,
	output logic [NUM_UNITS-1:0] O_DISP_VALID,
	output logic [NUM_UNITS-1:0][TAG_W-1:0] O_DISP_TAG,
	output logic [NUM_UNITS-1:0][1:0] O_DISP_SRC_SEL,
	output logic [NUM_UNITS-1:0][AREG_W-1:0] O_DISP_SRC_REG,
	output logic [NUM_UNITS-1:0][TAG_W-1:0] O_DISP_SRC_RR,
	output logic [NUM_UNITS-1:0] O_RR_WE,
	output logic [NUM_UNITS-1:0][TAG_W-1:0] O_RR_WTAG,
	output logic [RET_MAX-1:0] O_RET_VALID,
	output logic [RET_MAX-1:0][TAG_W-1:0] O_RET_RR,
	output logic [RET_MAX-1:0] O_RET_HAS_DEST,
	output logic [RET_MAX-1:0][AREG_W-1:0] O_RET_DEST,
	output logic [RET_MAX-1:0] O_RET_CTR,
	output logic [RET_MAX-1:0] O_RET_LR,
	output logic O_FLUSH,
	output logic [VEC_W-1:0] O_REDIRECT_VEC,
	output logic [NUM_UNITS-1:0] O_UNIT_HALTED
);
	////////////////////////////////////////////////////////////////////////////
	// declarations
	spc_iqe_t iq_r [IQ_DEPTH];
	spc_iqe_t iq_nxt [IQ_DEPTH];
	logic [CNT_W-1:0] iq_cnt_r, iq_cnt_nxt;
	logic [NUM_AREGS-1:0] map_v_r, map_v_nxt;
	logic [NUM_AREGS-1:0][TAG_W-1:0] map_t_r, map_t_nxt;
	logic [NUM_UNITS-1:0] halt_r, halt_nxt;
	logic [NUM_UNITS-1:0] issue;
	logic [NUM_UNITS-1:0][TAG_W-1:0] dtag;
	logic [NUM_UNITS-1:0][1:0] dsel;
	logic [NUM_UNITS-1:0][AREG_W-1:0] dsreg;
	logic [NUM_UNITS-1:0][TAG_W-1:0] dsrr;
	logic [NUM_UNITS-1:0] pipe_rdy, fin;
	logic [NUM_UNITS-1:0][TAG_W-1:0] fin_tag;
	logic [1:0] alloc_n;
	spc_cqe_t alloc_ent [DISP_SCAN];
	logic [TAG_W-1:0] cq_tail;
	logic [CNT_W-1:0] cq_free;
	logic [CQ_DEPTH-1:0] cq_done;
	logic [RET_MAX-1:0] ret;
	logic [RET_MAX-1:0][TAG_W-1:0] ret_tag;
	spc_cqe_t ret_ent [RET_MAX];
	logic exc_take;
	logic [VEC_W-1:0] exc_vec;
	logic accept, fold;
	int nd;
	logic ready_r, fold_r, flush_r;
	logic [VEC_W-1:0] vec_r;
	logic [NUM_UNITS-1:0] dv_r, rrwe_r;
	logic [NUM_UNITS-1:0][TAG_W-1:0] dtag_r, rrtag_r, dsrr_r;
	logic [NUM_UNITS-1:0][1:0] dsel_r;
	logic [NUM_UNITS-1:0][AREG_W-1:0] dsreg_r;
	logic [RET_MAX-1:0] rv_r, rhd_r, rctr_r, rlr_r;
	logic [RET_MAX-1:0][TAG_W-1:0] rrr_r;
	logic [RET_MAX-1:0][AREG_W-1:0] rdest_r;

	////////////////////////////////////////////////////////////////////////////
	// execution unit staging, one pipe per unit
	for (genvar gu = 0; gu < NUM_UNITS; gu++) begin : g_unit
		// fpu runs three stages, lsu two, the rest one
		spc_xpipe #(
			.DEPTH(unit_stages(gu))
		) u_pipe (
			.i_clk(I_CLOCK),
			.i_srst(I_SRST),
			.i_flush(exc_take),
			.i_issue(issue[gu]),
			.i_tag(dtag[gu]),
			.i_hold(I_UNIT_HOLD[gu]),
			.o_ready(pipe_rdy[gu]),
			.o_fin(fin[gu]),
			.o_fin_tag(fin_tag[gu])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// completion queue
	spc_cq u_cq (
		.i_clk(I_CLOCK),
		.i_srst(I_SRST),
		.i_alloc_n(alloc_n),
		.i_alloc_ent(alloc_ent),
		.i_fin(fin),
		.i_exc(I_UNIT_EXC),
		.i_fin_tag(fin_tag),
		.i_vec(I_UNIT_VEC),
		.o_tail(cq_tail),
		.o_free(cq_free),
		.o_done(cq_done),
		.o_ret(ret),
		.o_ret_tag(ret_tag),
		.o_ret_ent(ret_ent),
		.o_exc_take(exc_take),
		.o_exc_vec(exc_vec)
	);

	////////////////////////////////////////////////////////////////////////////
	// fetch acceptance and branch folding
	assign accept = I_FETCH_VALID && ready_r && !exc_take;
	assign fold = accept && (I_FETCH_CLASS == C_BR) && !I_FETCH_UPD_CTR && !I_FETCH_UPD_LR;

	////////////////////////////////////////////////////////////////////////////
	// dispatch, rename map, instruction queue and unit halt next values
	always_comb begin
		int nb;
		int u;
		logic stop, br_used, ok;
		logic [NUM_UNITS-1:0] used;
		logic [NUM_AREGS-1:0] tmap_new;
		spc_iqe_t e;
		nd = 0;
		nb = 0;
		u = U_BR;
		stop = 1'b0;
		br_used = 1'b0;
		ok = 1'b0;
		used = '0;
		tmap_new = '0;
		e = '0;
		map_v_nxt = map_v_r;
		map_t_nxt = map_t_r;
		issue = '0;
		dtag = '0;
		dsel = '0;
		dsreg = '0;
		dsrr = '0;
		for (int k = 0; k < DISP_SCAN; k++) alloc_ent[k] = '0;
		// walk the oldest slots in order, stopping at the first that cannot go
		for (int k = 0; k < DISP_SCAN; k++) begin
			e = iq_r[k];
			unique case (e.cls)
				C_INT: u = (!used[U_INT0] && pipe_rdy[U_INT0] && !halt_r[U_INT0]) ? U_INT0 : U_INT1;
				C_FPU: u = U_FPU;
				C_LSU: u = U_LSU;
				C_SRU: u = U_SRU;
				default: u = U_BR;
			endcase
			// a free completion entry is also the free rename register
			ok = !stop && k < int'(iq_cnt_r) && !exc_take && nd < int'(cq_free);
			ok = ok && !used[u] && pipe_rdy[u] && !halt_r[u];
			if (e.cls == C_BR) ok = ok && !br_used;
			else ok = ok && k < DISP_NB_SLOTS && nb < DISP_NB_MAX;
			if (ok) begin
				used[u] = 1'b1;
				if (e.cls == C_BR) br_used = 1'b1;
				else nb = nb + 1;
				// the unit latches this on the coming edge
				issue[u] = 1'b1;
				dtag[u] = tag_add(cq_tail, nd);
				dsreg[u] = e.src;
				dsrr[u] = map_t_nxt[e.src];
				// operand from file, finished rename, or a wait tag
				if (!e.has_src || !map_v_nxt[e.src]) dsel[u] = SRC_ARCH;
				else if (!tmap_new[e.src] && cq_done[map_t_nxt[e.src]]) dsel[u] = SRC_RENAME;
				else dsel[u] = SRC_TAG;
				if (e.has_dest) begin
					map_v_nxt[e.dest] = 1'b1;
					map_t_nxt[e.dest] = tag_add(cq_tail, nd);
					tmap_new[e.dest] = 1'b1;
				end
				alloc_ent[nd] = '{has_dest: e.has_dest, dest: e.dest, ctr: e.ctr, lr: e.lr};
				nd = nd + 1;
			end else begin
				stop = 1'b1;
			end
		end
		alloc_n = 2'(nd);
		// a retired producer no longer supplies its register from rename
		for (int k = 0; k < RET_MAX; k++) begin
			for (int r = 0; r < NUM_AREGS; r++) begin
				if (ret[k] && map_v_r[r] && map_t_r[r] == ret_tag[k] && !tmap_new[r])
					map_v_nxt[r] = 1'b0;
			end
		end
		// drop dispatched slots, append the fetched instruction
		for (int i = 0; i < IQ_DEPTH; i++) begin
			iq_nxt[i] = (i + nd < IQ_DEPTH) ? iq_r[i+nd] : '0;
		end
		iq_cnt_nxt = CNT_W'(int'(iq_cnt_r) - nd);
		if (accept && !fold) begin
			iq_nxt[iq_cnt_nxt] = '{cls: spc_class_t'(I_FETCH_CLASS), has_src: I_FETCH_HAS_SRC,
				src: I_FETCH_SRC, has_dest: I_FETCH_HAS_DEST, dest: I_FETCH_DEST,
				ctr: I_FETCH_UPD_CTR, lr: I_FETCH_UPD_LR};
			iq_cnt_nxt = iq_cnt_nxt + 3'h1;
		end
		// a unit other than the fpu stops after reporting an exception
		halt_nxt = halt_r;
		for (int k = 0; k < NUM_UNITS; k++) begin
			if (fin[k] && I_UNIT_EXC[k] && k != U_FPU) halt_nxt[k] = 1'b1;
		end
		// exception at completion clears everything younger
		if (exc_take) begin
			iq_cnt_nxt = CNT_RST;
			map_v_nxt = '0;
			halt_nxt = '0;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			iq_cnt_r <= CNT_RST;
			map_v_r <= '0;
			map_t_r <= '0;
			halt_r <= '0;
			for (int i = 0; i < IQ_DEPTH; i++) iq_r[i] <= '0;
		end else begin
			iq_cnt_r <= iq_cnt_nxt;
			map_v_r <= map_v_nxt;
			map_t_r <= map_t_nxt;
			halt_r <= halt_nxt;
			iq_r <= iq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registered outputs: dispatch, rename write, retire, redirect
	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			ready_r <= 1'b0;
			fold_r <= 1'b0;
			flush_r <= 1'b0;
			vec_r <= '0;
			dv_r <= '0;
			dtag_r <= '0;
			dsel_r <= '0;
			dsreg_r <= '0;
			dsrr_r <= '0;
			rrwe_r <= '0;
			rrtag_r <= '0;
			rv_r <= '0;
			rrr_r <= '0;
			rhd_r <= '0;
			rdest_r <= '0;
			rctr_r <= '0;
			rlr_r <= '0;
		end else begin
			ready_r <= int'(iq_cnt_nxt) < IQ_DEPTH;
			fold_r <= fold;
			flush_r <= exc_take;
			vec_r <= exc_take ? exc_vec : vec_r;
			dv_r <= issue;
			dtag_r <= dtag;
			dsel_r <= dsel;
			dsreg_r <= dsreg;
			dsrr_r <= dsrr;
			rrwe_r <= fin;
			rrtag_r <= fin_tag;
			for (int k = 0; k < RET_MAX; k++) begin
				// copy rename to gpr/fpr and count/link on retire
				rv_r[k] <= ret[k];
				rrr_r[k] <= ret_tag[k];
				rhd_r[k] <= ret_ent[k].has_dest;
				rdest_r[k] <= ret_ent[k].dest;
				rctr_r[k] <= ret_ent[k].ctr;
				rlr_r[k] <= ret_ent[k].lr;
			end
		end
	end

	assign O_FETCH_READY = ready_r;
	assign O_BR_FOLD = fold_r;
	assign O_DISP_VALID = dv_r;
	assign O_DISP_TAG = dtag_r;
	assign O_DISP_SRC_SEL = dsel_r;
	assign O_DISP_SRC_REG = dsreg_r;
	assign O_DISP_SRC_RR = dsrr_r;
	assign O_RR_WE = rrwe_r;
	assign O_RR_WTAG = rrtag_r;
	assign O_RET_VALID = rv_r;
	assign O_RET_RR = rrr_r;
	assign O_RET_HAS_DEST = rhd_r;
	assign O_RET_DEST = rdest_r;
	assign O_RET_CTR = rctr_r;
	assign O_RET_LR = rlr_r;
	assign O_FLUSH = flush_r;
	assign O_REDIRECT_VEC = vec_r;
	assign O_UNIT_HALTED = halt_r;
endmodule

// >>> verif/spc_pc_sva.sv
////////////////////////////////////////////////////////////////////////////////
// port-level checks of the pipeline control
module spc_pc_sva
	import spc_pkg::*;
(
	input wire logic I_CLOCK,
	input wire logic I_SRST,
	input wire logic I_FETCH_VALID,
	input wire logic [2:0] I_FETCH_CLASS,
	input wire logic I_FETCH_UPD_CTR,
	input wire logic I_FETCH_UPD_LR,
	input wire logic [NUM_UNITS-1:0] I_UNIT_HOLD,
	input wire logic O_FETCH_READY,
	input wire logic O_BR_FOLD,
	input wire logic [NUM_UNITS-1:0] O_DISP_VALID,
	input wire logic [NUM_UNITS-1:0][TAG_W-1:0] O_DISP_TAG,
	input wire logic [NUM_UNITS-1:0] O_RR_WE,
	input wire logic [NUM_UNITS-1:0][TAG_W-1:0] O_RR_WTAG,
	input wire logic [RET_MAX-1:0] O_RET_VALID,
	input wire logic [RET_MAX-1:0][TAG_W-1:0] O_RET_RR,
	input wire logic O_FLUSH,
	input wire logic [NUM_UNITS-1:0] O_UNIT_HALTED
);
	logic [3:0] inflt_r, inflt_nxt;
	logic [TAG_W-1:0] nxt_ret_r, nxt_ret_nxt;
	logic seen_r, seen_nxt;

	// next entry around the six-entry ring
	function automatic logic [TAG_W-1:0] wrap_inc(input logic [TAG_W-1:0] t);
		return (t == 3'h5) ? 3'h0 : t + 3'h1;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// entries in flight and next tag due to retire; both forgotten on a flush
	always_comb begin
		inflt_nxt = inflt_r + 4'($countones(O_DISP_VALID)) - 4'($countones(O_RET_VALID));
		seen_nxt = seen_r | O_RET_VALID[0];
		nxt_ret_nxt = nxt_ret_r;
		if (O_RET_VALID[0])
			nxt_ret_nxt = wrap_inc(O_RET_VALID[1] ? O_RET_RR[1] : O_RET_RR[0]);
		if (O_FLUSH) begin
			inflt_nxt = 4'h0;
			seen_nxt = 1'b0;
		end
	end

	// registers of the helper state
	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			inflt_r <= 4'h0;
			seen_r <= 1'b0;
			nxt_ret_r <= 3'h0;
		end else begin
			inflt_r <= inflt_nxt;
			seen_r <= seen_nxt;
			nxt_ret_r <= nxt_ret_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (I_SRST);

	chk_fold_cause:
	assert property (O_BR_FOLD |-> $past(I_FETCH_VALID && O_FETCH_READY && I_FETCH_CLASS == 3'h4
		&& !I_FETCH_UPD_CTR && !I_FETCH_UPD_LR)) else $error("fold without plain branch");
	chk_fold_taken:
	assert property (I_FETCH_VALID && O_FETCH_READY && I_FETCH_CLASS == 3'h4 && !I_FETCH_UPD_CTR
		&& !I_FETCH_UPD_LR |=> O_BR_FOLD || O_FLUSH) else $error("plain branch not folded");
	chk_nonbr_two:
	assert property ($countones(O_DISP_VALID[4:0]) <= 2) else $error("too many non-branch issued");
	chk_cq_six:
	assert property ($countones(O_DISP_VALID) <= 3 && inflt_r <= 4'h6)
		else $error("dispatch beyond limits");
	chk_int_finish:
	assert property (O_DISP_VALID[0] && !I_UNIT_HOLD[0] && !O_FLUSH |=> O_FLUSH
		|| (O_RR_WE[0] && O_RR_WTAG[0] == $past(O_DISP_TAG[0]))) else $error("int finish late");
	chk_fpu_three:
	assert property (O_DISP_VALID[2] && !I_UNIT_HOLD[2] && !O_FLUSH ##1 !I_UNIT_HOLD[2] && !O_FLUSH
		##1 !I_UNIT_HOLD[2] && !O_FLUSH |=> O_FLUSH
		|| (O_RR_WE[2] && O_RR_WTAG[2] == $past(O_DISP_TAG[2], 3))) else $error("fpu depth");
	chk_lsu_two:
	assert property (O_DISP_VALID[3] && !I_UNIT_HOLD[3] && !O_FLUSH ##1 !I_UNIT_HOLD[3] && !O_FLUSH
		|=> O_FLUSH || (O_RR_WE[3] && O_RR_WTAG[3] == $past(O_DISP_TAG[3], 2)))
		else $error("lsu depth");
	chk_ret_pair:
	assert property (O_RET_VALID[1] |-> O_RET_VALID[0] && O_RET_RR[1] == wrap_inc(O_RET_RR[0]))
		else $error("retire lanes out of order");
	chk_ret_order:
	assert property (O_RET_VALID[0] && seen_r |-> O_RET_RR[0] == nxt_ret_r)
		else $error("retire skipped an entry");
	chk_halt_blocks:
	assert property ((O_UNIT_HALTED & $past(O_UNIT_HALTED) & O_DISP_VALID) == 6'h0
		&& !O_UNIT_HALTED[2]) else $error("halted unit issued");
	chk_flush_clear:
	assert property (O_FLUSH |=> !O_FLUSH && O_UNIT_HALTED == 6'h0 && O_RET_VALID == 2'h0)
		else $error("flush did not clear");

	cover property (O_BR_FOLD);
	cover property ($countones(O_DISP_VALID) == 3);
	cover property (O_RET_VALID == 2'h3);
	cover property (O_FLUSH);
endmodule

bind spc_pipe_ctrl spc_pc_sva chk_u (.I_CLOCK, .I_SRST, .I_FETCH_VALID, .I_FETCH_CLASS,
	.I_FETCH_UPD_CTR, .I_FETCH_UPD_LR, .I_UNIT_HOLD, .O_FETCH_READY, .O_BR_FOLD, .O_DISP_VALID,
	.O_DISP_TAG, .O_RR_WE, .O_RR_WTAG, .O_RET_VALID, .O_RET_RR, .O_FLUSH, .O_UNIT_HALTED);

// >>> verif/spc_unit_model.sv
////////////////////////////////////////////////////////////////////////////////
// execution units' reporting side: an armed dispatch excepts in its last stage
module spc_unit_model
	import spc_pkg::*;
(
	input wire logic i_clk,
	input wire logic [NUM_UNITS-1:0] i_arm,
	input wire logic [NUM_UNITS-1:0] i_disp_valid,
	output logic [NUM_UNITS-1:0] o_exc,
	output logic [NUM_UNITS-1:0][VEC_W-1:0] o_vec
);
	int depth [NUM_UNITS] = '{1, 1, 3, 2, 1, 1};
	int age [NUM_UNITS] = '{default: 0};

	// age the armed instruction; vector is only meaningful while reporting
	always @(negedge i_clk) begin
		for (int u = 0; u < NUM_UNITS; u++) begin
			if (i_disp_valid[u] && i_arm[u])
				age[u] = 1;
			else if (age[u] != 0)
				age[u] = (age[u] == depth[u]) ? 0 : age[u] + 1;
			o_exc[u] = (age[u] != 0) && (age[u] == depth[u]);
			o_vec[u] = {4'h0, 4'(u + 1), 8'h00} ^ {VEC_W{!o_exc[u]}};
		end
	end
endmodule

// >>> verif/tb_top.sv
////////////////////////////////////////////////////////////////////////////////
// self-checking bench of the pipeline control
module tb_top
	import spc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, srst, f_valid, f_has_src, f_has_dest, f_ctr, f_lr, ready, fold, flush;
	logic [2:0] f_cls;
	logic [3:0] f_src, f_dest;
	logic [5:0] hold, arm, uexc, dv, rrwe, halted;
	logic [5:0][15:0] uvec;
	logic [5:0][2:0] dtag, drr, rwtag;
	logic [5:0][1:0] dsel;
	logic [5:0][3:0] dreg;
	logic [1:0] rv, rhd, rctr, rlr;
	logic [1:0][2:0] rrr;
	logic [1:0][3:0] rdest;
	logic [15:0] rvec;
	logic [2:0] tag_e = 3'h0;
	int n_errors = 0;
	int n_compared = 0;

	spc_pipe_ctrl dut_u (.I_CLOCK(clk), .I_SRST(srst), .I_FETCH_VALID(f_valid),
		.I_FETCH_CLASS(f_cls), .I_FETCH_HAS_SRC(f_has_src), .I_FETCH_SRC(f_src),
		.I_FETCH_HAS_DEST(f_has_dest), .I_FETCH_DEST(f_dest), .I_FETCH_UPD_CTR(f_ctr),
		.I_FETCH_UPD_LR(f_lr), .I_UNIT_HOLD(hold), .I_UNIT_EXC(uexc), .I_UNIT_VEC(uvec),
		.O_FETCH_READY(ready), .O_BR_FOLD(fold), .O_DISP_VALID(dv), .O_DISP_TAG(dtag),
		.O_DISP_SRC_SEL(dsel), .O_DISP_SRC_REG(dreg), .O_DISP_SRC_RR(drr), .O_RR_WE(rrwe),
		.O_RR_WTAG(rwtag), .O_RET_VALID(rv), .O_RET_RR(rrr), .O_RET_HAS_DEST(rhd),
		.O_RET_DEST(rdest), .O_RET_CTR(rctr), .O_RET_LR(rlr), .O_FLUSH(flush),
		.O_REDIRECT_VEC(rvec), .O_UNIT_HALTED(halted));
	spc_unit_model um_u (.i_clk(clk), .i_arm(arm), .i_disp_valid(dv), .o_exc(uexc),
		.o_vec(uvec));

	// free-running clock
	always #5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	// comparison, fetch handshake and dispatch wait
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic fetch(input logic [2:0] c, input logic [4:0] s, input logic [4:0] d,
		input logic [1:0] cl);
		int n;
		n = 0;
		f_valid = 1'b1;
		f_cls = c;
		{f_has_src, f_src} = s;
		{f_has_dest, f_dest} = d;
		{f_ctr, f_lr} = cl;
		while (ready !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		if (n == 50) n_errors++;
		@(negedge clk);
	endtask

	task automatic wait_disp(input int u);
		int n;
		n = 0;
		while (dv[u] !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		check("dispatch seen", dv[u], 1'b1);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// one instruction per unit kind, exact stage timing and retired fields
	task automatic t_units();
		int un [5] = '{0, 2, 3, 4, 5};
		int dp [5] = '{1, 3, 2, 1, 1};
		logic [4:0] d;
		logic [1:0] cl;
		for (int c = 0; c < 5; c++) begin
			d = (c == 4) ? 5'h00 : {1'b1, c == 1, 3'(c + 1)};
			cl = (c == 4) ? 2'h1 : ((c == 3) ? 2'h2 : 2'h0);
			fetch(3'(c), 5'h00, d, cl);
			f_valid = 1'b0;
			@(negedge clk);
			check("dispatch", dv, 6'h1 << un[c]);
			check("tag", dtag[un[c]], tag_e);
			check("no source", dsel[un[c]], SRC_ARCH);
			repeat (dp[c]) @(negedge clk);
			check("finish", rrwe, 6'h1 << un[c]);
			check("finish tag", rwtag[un[c]], tag_e);
			@(negedge clk);
			check("retire", rv, 2'h1);
			check("retire fields", {rrr[0], rhd[0], rdest[0], rctr[0], rlr[0]}, {tag_e, d, cl});
			tag_e = (tag_e == 3'h5) ? 3'h0 : tag_e + 3'h1;
		end
		$display("t_units done");
	endtask

	// plain branch is folded and never reaches the branch unit
	task automatic t_fold();
		logic seen;
		seen = 1'b0;
		fetch(3'h4, 5'h00, 5'h00, 2'h0);
		f_valid = 1'b0;
		check("fold pulse", fold, 1'b1);
		repeat (5) begin
			@(negedge clk);
			seen = seen | dv[5] | fold;
		end
		check("folded not issued", seen, 1'b0);
		$display("t_fold done");
	endtask

	// a dependent operand waits on a tag, a settled one reads the file,
	// a finished but unretired one reads its rename register
	task automatic t_operand();
		fetch(3'h1, 5'h00, 5'h19, 2'h0);
		fetch(3'h1, 5'h19, 5'h1a, 2'h0);
		f_valid = 1'b0;
		@(negedge clk);
		wait_disp(2);
		check("tag wait", {dsel[2], drr[2]}, {SRC_TAG, tag_e});
		repeat (10) @(negedge clk);
		fetch(3'h1, 5'h19, 5'h1b, 2'h0);
		f_valid = 1'b0;
		wait_disp(2);
		check("file read", {dsel[2], dreg[2]}, {SRC_ARCH, 4'h9});
		repeat (10) @(negedge clk);
		// held fpu op blocks retire; producer finishes, consumer queues behind fpu
		hold = 6'h04;
		fetch(3'h1, 5'h00, 5'h00, 2'h0);
		fetch(3'h0, 5'h00, 5'h11, 2'h0);
		fetch(3'h1, 5'h00, 5'h00, 2'h0);
		fetch(3'h0, 5'h11, 5'h13, 2'h0);
		f_valid = 1'b0;
		repeat (2) @(negedge clk);
		hold = 6'h00;
		wait_disp(0);
		check("rename read", {dsel[0], drr[0]}, {SRC_RENAME, 3'h3});
		repeat (10) @(negedge clk);
		$display("t_operand done");
	endtask

	// held units fill, three queued issue together, then pairs retire
	task automatic t_dual();
		int n;
		n = 0;
		hold = 6'h23;
		// the first three park in the held units, the next three queue behind them
		repeat (2) begin
			fetch(3'h0, 5'h00, 5'h11, 2'h0);
			fetch(3'h0, 5'h00, 5'h12, 2'h0);
			fetch(3'h4, 5'h00, 5'h00, 2'h1);
		end
		f_valid = 1'b0;
		hold = 6'h00;
		wait_disp(0);
		check("triple issue", dv, 6'h23);
		while (rv === 2'h0 && n < 10) begin
			@(negedge clk);
			n++;
		end
		check("dual retire", rv, 2'h3);
		check("lane order", {rrr[0], rrr[1]}, {tag_e, 3'(tag_e == 3'h5 ? 0 : tag_e + 1)});
		@(negedge clk);
		check("second pair", rv, 2'h3);
		check("second lanes", {rrr[0], rrr[1]}, {3'(tag_e + 2), 3'(tag_e + 3)});
		repeat (4) @(negedge clk);
		$display("t_dual done");
	endtask

	// younger int excepts under an older fpu op: taken only at the head
	task automatic t_exc();
		logic [2:0] ta;
		logic ret_a, fl, halt, young;
		ta = tag_e;
		{ret_a, fl, halt, young} = 4'h0;
		arm = 6'h01;
		fetch(3'h1, 5'h00, 5'h19, 2'h0);
		fetch(3'h0, 5'h00, 5'h11, 2'h0);
		fetch(3'h2, 5'h00, 5'h12, 2'h0);
		f_valid = 1'b0;
		repeat (20) begin
			@(negedge clk);
			ret_a = ret_a | (rv[0] === 1'b1 && rrr[0] === ta && !fl);
			young = young | (rv[0] === 1'b1 && rrr[0] !== ta);
			halt = halt | (halted[0] === 1'b1 && !fl);
			if (flush === 1'b1) begin
				fl = 1'b1;
				check("vector", rvec, 16'h0100);
			end
		end
		check("older retired first", ret_a, 1'b1);
		check("unit halted", halt, 1'b1);
		check("flush seen", fl, 1'b1);
		check("younger cancelled", young, 1'b0);
		check("halt cleared", halted, 6'h0);
		arm = 6'h00;
		$display("t_exc done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// watchdog well beyond the expected run length
	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		complete_run();
	end

	// reset, then the scenarios
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		{f_valid, f_cls, f_has_src, f_src, f_has_dest, f_dest, f_ctr, f_lr} = '0;
		hold = 6'h00;
		arm = 6'h00;
		repeat (3) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		t_fold();
		t_units();
		t_operand();
		tag_e = 3'h0;
		t_dual();
		t_exc();
		complete_run();
	end
endmodule
